// ### common/tap_pkg.sv
// Shared constants and types for the test access port and debug event block.
// Assumes a single system clock that oversamples the test clock pin.
package tap_pkg;

  // ==========================================================================
  // Test controller states (standard sixteen-state sequence).
  typedef enum logic [3:0]
  {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SHIFT_DR = 4'h4,
    ST_EXIT1_DR = 4'h5,
    ST_PAUSE_DR = 4'h6,
    ST_EXIT2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SHIFT_IR = 4'hb,
    ST_EXIT1_IR = 4'hc,
    ST_PAUSE_IR = 4'hd,
    ST_EXIT2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } tap_state_t;

  // ==========================================================================
  // Instruction register layout and codes.
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_IDCODE = 4'h2;
  localparam logic [3:0] IR_DEBUG_REQ = 4'h8;

  // Identification word; the value is arbitrary, bit 0 set as required.
  localparam logic [31:0] IDCODE_VALUE = 32'h0000_1001;

  // Number of system clocks across the two-stage pin synchronisers.
  localparam int SYNC_STAGES = 2;

  // Reset values of outputs.
  localparam logic TDO_RESET = 1'b0;
  localparam logic TDO_OE_N_RESET = 1'b1;

endpackage

// ### rtl/jtag_debug_event_port.sv
// Test access port controller with debug event lines for a multi-core part.
// Assumes CLK runs well above the test clock; test clock, mode select,
// data in and the test reset arrive from pins and are oversampled.
//
// Operation
// - Test data in is captured on test clock rising edges in shift-IR and shift-DR.
// - Test data out is driven only in shift-IR or shift-DR, else released.
// - Test data out changes only on falling test clock edges or on test reset.
// - The controller steps on rising test clock edges by mode select.
// - Test reset forces the controller to reset with no test clock edge.
// - A debug request puts the processor cores into debug mode.
// - Debug status is the OR of all per-core debug states.
// - All core emulation modules share one request and one status line.
// - The port offers the standard five-signal boundary-scan set.
`timescale 1ns/10ps
module jtag_debug_event_port
  import tap_pkg::*;
#(
  parameter int NUM_CORES = 4
)
(
  // System clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Test access port pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic TRST,
  output logic TDO,
  output logic TDO_OE_N,
  // Debug event pins
  input wire logic DEBUG_REQUEST_IN,
  output logic DEBUG_STATUS_OUT,
  // Core emulation module side
  input wire logic [NUM_CORES-1:0] CORE_IN_DEBUG,
  output logic [NUM_CORES-1:0] CORE_DEBUG_ENTER
);

  initial
  begin
    if (NUM_CORES < 1 || NUM_CORES > 32)
      $error("jtag_debug_event_port: NUM_CORES must be 1 to 32");
  end

  // ==========================================================================
  // Pin synchronisers.
  logic [4:0] pin_raw;
  logic [4:0] pin_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s;
  logic dbg_req_s;

  assign pin_raw = {DEBUG_REQUEST_IN, TRST, TDI, TMS, TCK};

  pin_sync #(
    .WIDTH(5)
  ) u_sync (
    .CLK(CLK),
    .RST(RST),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign tck_s = pin_s[0];
  assign tms_s = pin_s[1];
  assign tdi_s = pin_s[2];
  assign trst_s = pin_s[3];
  assign dbg_req_s = pin_s[4];

  // ==========================================================================
  // Test clock edge detection.
  logic tck_q;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      tck_q <= 1'b0;
    else
      tck_q <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_q;
  assign tck_fall = ~tck_s & tck_q;

  // ==========================================================================
  // Controller state machine.
  // The test reset is a pin level, so it is synchronised and then acts at
  // once on the next system clock, independent of any test clock edge.
  tap_state_t state_q;
  tap_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      state_q <= ST_RESET;
    else if (trst_s)
      state_q <= ST_RESET;
    else if (tck_rise)
      state_q <= state_d;
  end

  // ==========================================================================
  // Instruction and data registers.
  logic [IR_WIDTH-1:0] ir_shift_q;
  logic [IR_WIDTH-1:0] ir_q;
  logic bypass_q;
  logic [31:0] id_shift_q;
  logic debug_req_reg_q;
  logic shift_out;
  logic shifting;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ir_shift_q <= '0;
      ir_q <= IR_IDCODE;
    end
    else if (trst_s || state_q == ST_RESET)
    begin
      ir_shift_q <= '0;
      ir_q <= IR_IDCODE;
    end
    else if (tck_rise)
    begin
      case (state_q)
        ST_CAP_IR: ir_shift_q <= IR_CAPTURE;
        ST_SHIFT_IR: ir_shift_q <= {tdi_s, ir_shift_q[IR_WIDTH-1:1]};
        ST_UPD_IR: ir_q <= ir_shift_q;
        default: ir_shift_q <= ir_shift_q;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      bypass_q <= 1'b0;
      id_shift_q <= '0;
    end
    else if (tck_rise && state_q == ST_CAP_DR)
    begin
      bypass_q <= 1'b0;
      id_shift_q <= (ir_q == IR_IDCODE) ? IDCODE_VALUE
                    : {31'h0, debug_req_reg_q};
    end
    else if (tck_rise && state_q == ST_SHIFT_DR)
    begin
      bypass_q <= tdi_s;
      if (ir_q == IR_IDCODE)
        id_shift_q <= {tdi_s, id_shift_q[31:1]};
      else if (ir_q == IR_DEBUG_REQ)
        id_shift_q <= {31'h0, tdi_s};
    end
  end

  // A one-bit data register lets the tester request debug entry too.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      debug_req_reg_q <= 1'b0;
    else if (trst_s || state_q == ST_RESET)
      debug_req_reg_q <= 1'b0;
    else if (tck_rise && state_q == ST_UPD_DR && ir_q == IR_DEBUG_REQ)
      debug_req_reg_q <= id_shift_q[0];
  end

  always_comb
  begin
    if (state_q == ST_SHIFT_IR)
      shift_out = ir_shift_q[0];
    else if (ir_q == IR_IDCODE || ir_q == IR_DEBUG_REQ)
      shift_out = id_shift_q[0];
    else
      shift_out = bypass_q;
  end

  assign shifting = state_q == ST_SHIFT_IR || state_q == ST_SHIFT_DR;

  // ==========================================================================
  // Serial output, updated on falling test clock edges and cleared by test reset.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      TDO <= TDO_RESET;
      TDO_OE_N <= TDO_OE_N_RESET;
    end
    else if (trst_s)
    begin
      TDO <= TDO_RESET;
      TDO_OE_N <= TDO_OE_N_RESET;
    end
    else if (tck_fall)
    begin
      // A released line rests low, so no stale bit lingers behind it.
      TDO <= shifting ? shift_out : TDO_RESET;
      TDO_OE_N <= ~shifting;
    end
  end

  // ==========================================================================
  // Debug event lines, one pair shared by every core.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      CORE_DEBUG_ENTER <= '0;
      DEBUG_STATUS_OUT <= 1'b0;
    end
    else
    begin
      CORE_DEBUG_ENTER <=
        {NUM_CORES{dbg_req_s | debug_req_reg_q}};
      DEBUG_STATUS_OUT <= |CORE_IN_DEBUG;
    end
  end

endmodule

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to CLK; the first stage feeds only the
// second.
`timescale 1ns/10ps
module pin_sync
  import tap_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### verification/jtag_props.sv
// Checker for the test pins and debug event pins of the port block.
// Assumes a bind to the block; it sees only the block's own pins.
`timescale 1ns/10ps
module jtag_props
  import tap_pkg::*;
#(
  parameter int NUM_CORES = 4
)
(
  // Clock and resets
  input wire logic CLK,
  input wire logic RST,
  input wire logic TRST,
  // Pins
  input wire logic TCK,
  input wire logic TDO,
  input wire logic TDO_OE_N,
  input wire logic DEBUG_REQUEST_IN,
  input wire logic DEBUG_STATUS_OUT,
  input wire logic [NUM_CORES-1:0] CORE_IN_DEBUG,
  input wire logic [NUM_CORES-1:0] CORE_DEBUG_ENTER
);
  // ====================
  // Helpers
  // Test reset moves the outputs too, so edge checks skip its wake.
  logic [4:0] trst_q;
  logic quiet;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      trst_q <= '0;
    else
      trst_q <= {trst_q[3:0], TRST};
  end
  assign quiet = !TRST && trst_q == '0;
  // ====================
  // Properties
  tdo_on_fall_a:
    assert property ($changed(TDO) && quiet |-> !$past(TCK, 2))
    else $error("Data out moved off a clock fall.");
  oe_on_fall_a:
    assert property ($changed(TDO_OE_N) && quiet |-> !$past(TCK, 2))
    else $error("Data out enable moved off a clock fall.");
  idle_low_a:
    assert property (TDO_OE_N |-> TDO == TDO_RESET)
    else $error("Released data out not low.");
  trst_release_a:
    assert property (TRST [*4] |-> TDO_OE_N)
    else $error("Test reset left data out driven.");
  req_enter_a:
    assert property (DEBUG_REQUEST_IN |-> ##3 (&CORE_DEBUG_ENTER))
    else $error("Debug request not passed to cores.");
  enter_shared_a:
    assert property (CORE_DEBUG_ENTER == '0 || &CORE_DEBUG_ENTER)
    else $error("Cores given different debug entry.");
  status_set_a:
    assert property (|CORE_IN_DEBUG |=> DEBUG_STATUS_OUT)
    else $error("Debug status missing.");
  status_clr_a:
    assert property (!(|CORE_IN_DEBUG) |=> !DEBUG_STATUS_OUT)
    else $error("Debug status stuck.");
  cover property (!TDO_OE_N);
  cover property (&CORE_DEBUG_ENTER);
  cover property (DEBUG_STATUS_OUT);
endmodule

// ### verification/tap_probe.sv
// Model of the external tester that drives the test access pins.
// Assumes calls begin just after a rising CLK edge; TCK rests low.
`timescale 1ns/10ps
module tap_probe
(
  // Clock
  input wire logic CLK,
  // Tester pins
  output logic TCK,
  output logic TMS,
  output logic TDI,
  output logic TRST,
  input wire logic TDO
);
  // ====================
  // Pin drive
  // Test reset starts high so the controller wakes initialised.
  initial
  begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
    TRST = 1'b1;
  end
  task automatic set_trst(input logic v);
    TRST <= v;
  endtask
  // One 64 ns clock: inputs settle 5 CLK before the rise and hold 3 after;
  // data out is taken at the rise, well past its update on the fall.
  task automatic step(input logic m, input logic d, output logic q);
    TMS <= m;
    TDI <= d;
    repeat (5) @(posedge CLK);
    q = TDO;
    TCK <= 1'b1;
    repeat (3) @(posedge CLK);
    TCK <= 1'b0;
  endtask
endmodule

// ### verification/tb.sv
// Bench for the test port and debug event block.
// Assumes the probe drives the test pins and the bench the event pins.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("FAIL %0t mismatch", $time); end end
module tb
  import tap_pkg::*;
;
  localparam int NUM_CORES = 4;
  localparam logic [NUM_CORES-1:0] ALL = '1;
  logic CLK, RST, TCK, TMS, TDI, TRST, TDO, TDO_OE_N;
  logic DEBUG_REQUEST_IN, DEBUG_STATUS_OUT;
  logic [NUM_CORES-1:0] CORE_IN_DEBUG, CORE_DEBUG_ENTER;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  // ====================
  // Parts
  jtag_debug_event_port #(.NUM_CORES(NUM_CORES)) DUT (.CLK(CLK), .RST(RST),
    .TCK(TCK), .TMS(TMS), .TDI(TDI), .TRST(TRST), .TDO(TDO),
    .TDO_OE_N(TDO_OE_N), .DEBUG_REQUEST_IN(DEBUG_REQUEST_IN),
    .DEBUG_STATUS_OUT(DEBUG_STATUS_OUT), .CORE_IN_DEBUG(CORE_IN_DEBUG),
    .CORE_DEBUG_ENTER(CORE_DEBUG_ENTER));
  tap_probe probe (.CLK(CLK), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TRST(TRST), .TDO(TDO));
  // ====================
  // Helpers
  task automatic go(input logic [7:0] t, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      probe.step(t[i], 1'b0, b);
  endtask
  task automatic shift(input int n, input logic [31:0] d,
    output logic [31:0] q);
    logic b;
    logic oe;
    oe = 1'b0;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      probe.step(i == n - 1, d[i], b);
      q[i] = b;
      oe = oe | TDO_OE_N;
    end
    `CHK(oe, 1'b0)
  endtask
  // ====================
  // Scenarios
  task automatic s_idcode();
    logic [31:0] q;
    go(8'h01, 3);
    go(8'h1f, 6);
    `CHK(TDO_OE_N, 1'b1)
    go(8'h01, 3);
    shift(32, 32'h0, q);
    `CHK(q, IDCODE_VALUE)
    go(8'h01, 2);
    repeat (5) @(posedge CLK);
    `CHK(TDO_OE_N, 1'b1)
  endtask
  task automatic s_debug();
    logic [31:0] q;
    go(8'h03, 4);
    shift(4, 32'(IR_DEBUG_REQ), q);
    `CHK(q[3:0], IR_CAPTURE)
    go(8'h03, 4);
    shift(1, 32'h1, q);
    go(8'h01, 2);
    repeat (5) @(posedge CLK);
    `CHK(CORE_DEBUG_ENTER, ALL)
    go(8'h01, 3);
    repeat (5) @(posedge CLK);
    `CHK(TDO_OE_N, 1'b0)
    `CHK(TDO, 1'b1)
    probe.set_trst(1'b1);
    repeat (6) @(posedge CLK);
    `CHK(CORE_DEBUG_ENTER, '0)
    `CHK(TDO_OE_N, 1'b1)
    `CHK(TDO, TDO_RESET)
    probe.set_trst(1'b0);
    repeat (4) @(posedge CLK);
    go(8'h00, 1);
  endtask
  task automatic s_bypass();
    logic [31:0] q;
    go(8'h03, 4);
    shift(4, 32'(IR_BYPASS), q);
    go(8'h03, 4);
    shift(8, 32'ha5, q);
    `CHK(q[7:0], 8'h4a)
    go(8'h01, 2);
  endtask
  task automatic s_events();
    DEBUG_REQUEST_IN <= 1'b1;
    repeat (4) @(posedge CLK);
    `CHK(CORE_DEBUG_ENTER, ALL)
    DEBUG_REQUEST_IN <= 1'b0;
    repeat (4) @(posedge CLK);
    `CHK(CORE_DEBUG_ENTER, '0)
    for (int i = 0; i < NUM_CORES; i++)
    begin
      CORE_IN_DEBUG <= NUM_CORES'(1) << i;
      repeat (2) @(posedge CLK);
      `CHK(DEBUG_STATUS_OUT, 1'b1)
    end
    CORE_IN_DEBUG <= '0;
    repeat (2) @(posedge CLK);
    `CHK(DEBUG_STATUS_OUT, 1'b0)
  endtask
  // ====================
  // Run control
  task automatic finish_test();
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // The whole run needs about 1,100 cycles.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("FAIL %0t timeout", $time);
      finish_test();
    end
  end
  initial
  begin
    RST = 1'b1;
    DEBUG_REQUEST_IN = 1'b0;
    CORE_IN_DEBUG = '0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    probe.set_trst(1'b0);
    repeat (4) @(posedge CLK);
    s_idcode();
    s_debug();
    s_bypass();
    s_idcode();
    s_events();
    finish_test();
  end
endmodule
bind jtag_debug_event_port jtag_props #(.NUM_CORES(NUM_CORES)) props (
  .CLK(CLK), .RST(RST), .TRST(TRST), .TCK(TCK), .TDO(TDO),
  .TDO_OE_N(TDO_OE_N), .DEBUG_REQUEST_IN(DEBUG_REQUEST_IN),
  .DEBUG_STATUS_OUT(DEBUG_STATUS_OUT), .CORE_IN_DEBUG(CORE_IN_DEBUG),
  .CORE_DEBUG_ENTER(CORE_DEBUG_ENTER));
